// *** hdl/physical_request_node_filter.sv ***
// Purpose: Per-node physical and asynchronous request filters with AHB-Lite access
// Assumes: Request inputs synchronous to clk; single word transfers only
// Notes: Routing decision is registered one cycle after the request
// Operation
// - Lower physical filter enables physical handling per local node 0 to 31.
// - Physical-bound packets are checked again against physical filter after asynchronous filter.
// - Physical filter bit zero sends request to async receive request context instead.
// - Upper physical filter bits 17..0 select local nodes 49..32.
// - Lower physical filter bit n enables physical handling of local node n.
// - Lower filter has set and clear addresses, ones act, reset zero.
// - Physical upper bound register reads zero, writes ignored.
// - Upper physical filter bits 30..18 select local nodes 62..50.
// - Upper filter bit 31 accepts all requests from other buses.
// - Asynchronous filter bit for a local node accepts it, checked first.
`timescale 1ns/1ps
`default_nettype none
`include "prfilt_regs.svh"

module physical_request_node_filter (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire prfilt_pkg::word_t hwdata,
	output prfilt_pkg::word_t hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire prfilt_pkg::req_s req,
	output prfilt_pkg::decision_s decision
);
	import prfilt_pkg::*;

	localparam int NREG = 4;

	// ----------------------------------------------------------------
	// Bus address phase capture
	// ----------------------------------------------------------------
	logic wen_d, wen_q, ren_d, ren_q;
	logic [`OFS_W-1:0] addr_d, addr_q;
	word_t hrdata_d, hrdata_q;
	logic accept_phase;

	assign accept_phase = hsel && htrans[1] && hready;

	// Address phase is latched; write data follows one cycle later
	always_comb begin
		wen_d = accept_phase && hwrite;
		ren_d = accept_phase && !hwrite;
		addr_d = accept_phase ? haddr[`OFS_W-1:0] : addr_q;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wen_q <= 1'b0;
			ren_q <= 1'b0;
			addr_q <= '0;
		end else begin
			wen_q <= wen_d;
			ren_q <= ren_d;
			addr_q <= addr_d;
		end
	end

	// ----------------------------------------------------------------
	// Filter words: 0 async high, 1 async low, 2 phys high, 3 phys low
	// ----------------------------------------------------------------
	logic [`OFS_W-1:0] set_ofs [NREG];
	logic [`OFS_W-1:0] clr_ofs [NREG];
	word_t flt_d [NREG];
	word_t flt_q [NREG];

	assign set_ofs[0] = `ASYNC_HIGH_SET_OFS;
	assign clr_ofs[0] = `ASYNC_HIGH_CLR_OFS;
	assign set_ofs[1] = `ASYNC_LOW_SET_OFS;
	assign clr_ofs[1] = `ASYNC_LOW_CLR_OFS;
	assign set_ofs[2] = `PHYS_HIGH_SET_OFS;
	assign clr_ofs[2] = `PHYS_HIGH_CLR_OFS;
	assign set_ofs[3] = `PHYS_LOW_SET_OFS;
	assign clr_ofs[3] = `PHYS_LOW_CLR_OFS;

	// Writes land in the data phase; the bound offset has no word, so writes vanish
	for (genvar i = 0; i < NREG; i++) begin : g_word
		filter_word #(
			.W(32)
		) u_word (
			.clk(clk),
			.rst(rst),
			.set_en(wen_q && addr_q == set_ofs[i]),
			.clr_en(wen_q && addr_q == clr_ofs[i]),
			.wdata(hwdata),
			.word_d(flt_d[i]),
			.word_q(flt_q[i])
		);
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	// Reads use next values so a read right after a write sees it, no wait state
	always_comb begin
		hrdata_d = hrdata_q;
		if (ren_d) begin
			hrdata_d = '0;
			for (int i = 0; i < NREG; i++) begin
				if (haddr[`OFS_W-1:0] == set_ofs[i] || haddr[`OFS_W-1:0] == clr_ofs[i]) begin
					hrdata_d = flt_d[i];
				end
			end
			if (haddr[`OFS_W-1:0] == `PHYS_BOUND_OFS) begin
				hrdata_d = `BOUND_VALUE;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hrdata_q <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hrdata_q <= hrdata_d;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end
	assign hrdata = hrdata_q;

	// ----------------------------------------------------------------
	// Node lookup
	// ----------------------------------------------------------------
	// Node 63 is broadcast and never has an enable bit
	logic [63:0] async_nodes, phys_nodes;
	assign async_nodes = {1'b0, flt_q[0][`HIGH_NODE_BITS-1:0], flt_q[1]};
	assign phys_nodes = {1'b0, flt_q[2][`HIGH_NODE_BITS-1:0], flt_q[3]};

	decision_s dec_d, dec_q;
	logic remote_all, acc, phys_ok;

	// Asynchronous filter is checked first, then physical bits for physical packets
	always_comb begin
		remote_all = flt_q[2][`ALL_BUS_BIT] || flt_q[0][`ALL_BUS_BIT];
		acc = req.local_bus ? async_nodes[req.node] : remote_all;
		phys_ok = req.local_bus ? phys_nodes[req.node] : flt_q[2][`ALL_BUS_BIT];
		dec_d.valid = req.valid;
		dec_d.accepted = req.valid && acc;
		dec_d.to_phys = req.valid && acc && req.phys && phys_ok;
		dec_d.to_async = req.valid && acc && !(req.phys && phys_ok);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dec_q <= '0;
		end else begin
			dec_q <= dec_d;
		end
	end
	assign decision = dec_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_local_phys;
		req.valid && req.phys && req.local_bus && async_nodes[req.node];
	endsequence

	sequence s_write_at(logic [`OFS_W-1:0] ofs);
		wen_q && addr_q == ofs;
	endsequence

	a_lower_set_bits: assert property (@(posedge clk) disable iff (rst)
		s_write_at(`PHYS_LOW_SET_OFS) |=> ((flt_q[3] & $past(hwdata)) == $past(hwdata)))
		else $error("lower filter set write lost bits");

	a_lower_clear_bits: assert property (@(posedge clk) disable iff (rst)
		s_write_at(`PHYS_LOW_CLR_OFS) |=> ((flt_q[3] & $past(hwdata)) == '0)
			&& (flt_q[3] == ($past(flt_q[3]) & ~$past(hwdata))))
		else $error("lower filter clear write wrong");

	a_bound_reads_zero: assert property (@(posedge clk) disable iff (rst)
		ren_d && haddr[`OFS_W-1:0] == `PHYS_BOUND_OFS |=> hrdata == '0)
		else $error("upper bound register not zero");

	a_read_keeps_filter: assert property (@(posedge clk) disable iff (rst)
		ren_q && !wen_q |=> $stable(flt_q[3]) && $stable(flt_q[2]))
		else $error("read changed a filter");

	a_read_returns_low: assert property (@(posedge clk) disable iff (rst)
		ren_d && !wen_q && haddr[`OFS_W-1:0] == `PHYS_LOW_CLR_OFS |=> hrdata == flt_q[3])
		else $error("read of clear address wrong");

	a_low_node_route: assert property (@(posedge clk) disable iff (rst)
		s_local_phys and (req.node < `UPPER_NODE_BASE)
		|=> decision.to_phys == $past(flt_q[3][req.node[4:0]]) && decision.accepted)
		else $error("lower node routed wrong");

	a_high_node_route: assert property (@(posedge clk) disable iff (rst)
		s_local_phys and (req.node >= `UPPER_NODE_BASE) and (req.node != `BROADCAST_NODE)
		|=> decision.to_phys == $past(flt_q[2][req.node[4:0]]))
		else $error("upper node routed wrong");

	a_fallback_async: assert property (@(posedge clk) disable iff (rst)
		s_local_phys and !phys_nodes[req.node] |=> decision.to_async && !decision.to_phys)
		else $error("disabled node not sent to async context");

	a_async_first: assert property (@(posedge clk) disable iff (rst)
		req.valid && req.local_bus && !async_nodes[req.node]
		|=> !decision.accepted && !decision.to_phys && !decision.to_async)
		else $error("unfiltered node accepted");

	a_remote_all: assert property (@(posedge clk) disable iff (rst)
		req.valid && !req.local_bus && flt_q[2][`ALL_BUS_BIT] |=> decision.accepted)
		else $error("remote bus request refused");

	a_bus_okay: assert property (@(posedge clk) disable iff (rst)
		hreadyout && !hresp)
		else $error("bus answer not ready okay");

endmodule
`default_nettype wire

// *** inc/prfilt_regs.svh ***
// Purpose: Register offsets, reset values and field positions of the node filter bank
// Assumes: Byte addresses on a 32-bit AHB-Lite bus, one aligned word per register
// Notes: Definitions only
`ifndef PRFILT_REGS_SVH
`define PRFILT_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ASYNC_HIGH_SET_OFS 12'h100
`define ASYNC_HIGH_CLR_OFS 12'h104
`define ASYNC_LOW_SET_OFS 12'h108
`define ASYNC_LOW_CLR_OFS 12'h10c
`define PHYS_HIGH_SET_OFS 12'h110
`define PHYS_HIGH_CLR_OFS 12'h114
`define PHYS_LOW_SET_OFS 12'h118
`define PHYS_LOW_CLR_OFS 12'h11c
`define PHYS_BOUND_OFS 12'h120
`define OFS_W 12

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define FILTER_RESET 32'h0000_0000
`define BOUND_VALUE 32'h0000_0000
`define ALL_BUS_BIT 31
`define NODE_W 6
`define UPPER_NODE_BASE 6'h20
`define HIGH_NODE_BITS 31
`define BROADCAST_NODE 6'h3f

`endif

// *** inc/prfilt_pkg.sv ***
// Purpose: Types shared by the node filter bank
// Assumes: prfilt_regs.svh supplies the widths
// Notes: Request and routing decision travel as packed structs
`default_nettype none
`include "prfilt_regs.svh"

package prfilt_pkg;

	// Incoming request as seen by the receive path
	typedef struct packed {
		logic valid;
		logic phys;
		logic local_bus;
		logic [`NODE_W-1:0] node;
	} req_s;

	// Registered routing decision
	typedef struct packed {
		logic valid;
		logic accepted;
		logic to_phys;
		logic to_async;
	} decision_s;

	typedef logic [31:0] word_t;

endpackage
`default_nettype wire

// *** hdl/filter_word.sv ***
// Purpose: One set/clear filter word
// Assumes: At most one write strobe per cycle
// Notes: Exposes the next value so the bus can read without a wait state
`timescale 1ns/1ps
`default_nettype none
`include "prfilt_regs.svh"

module filter_word #(
	parameter int W = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic set_en,
	input wire logic clr_en,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] word_d,
	output logic [W-1:0] word_q
);

	// ----------------------------------------------------------------
	// Next value: ones set or clear, zeros leave bits alone
	// ----------------------------------------------------------------
	always_comb begin
		word_d = word_q;
		if (set_en) begin
			word_d = word_q | wdata;
		end else if (clr_en) begin
			word_d = word_q & ~wdata;
		end
	end

	// Storage, cleared by reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			word_q <= W'(`FILTER_RESET);
		end else begin
			word_q <= word_d;
		end
	end

endmodule
`default_nettype wire

// *** test/node_source.sv ***
// Purpose: Remote node model that issues requests to the filter
// Assumes: One request per command cycle
// Notes: Idle fields toggle so a stale value never passes for a live one
`timescale 1ns/1ps
`default_nettype none

module node_source (
	input wire logic clk,
	input wire logic rst,
	input wire logic fire,
	input wire logic phys,
	input wire logic local_bus,
	input wire logic [5:0] node,
	output prfilt_pkg::req_s req
);
	import prfilt_pkg::*;
	// Launch a request on command, otherwise scramble the released fields
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			req <= '0;
		end else if (fire) begin
			req <= '{1'b1, phys, local_bus, node};
		end else begin
			req <= '{1'b0, ~req.phys, ~req.local_bus, ~req.node};
		end
	end
endmodule

`default_nettype wire

// *** test/physical_request_node_filter_bench.sv ***
// Purpose: Self-checking bench for the node filter bank
// Assumes: Zero wait state bus, decision one cycle after each request
// Notes: Filters change only while no request is in flight
`timescale 1ns/1ps
`default_nettype none
`include "prfilt_regs.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
	$display("wrong value at %0t: %h vs %h", $time, a, b); end end

module physical_request_node_filter_bench;
	import prfilt_pkg::*;
	logic clk, rst, hsel, hwrite, fire, phys, local_bus, hreadyout, hresp;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [5:0] node;
	word_t hwdata, hrdata, lfsr;
	word_t flt[4];
	req_s req;
	decision_s decision, got_exp;
	decision_s exp_q[$];
	int n_mismatch, cmp_count;

	physical_request_node_filter uut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .req(req), .decision(decision));
	node_source src (.clk(clk), .rst(rst), .fire(fire), .phys(phys), .local_bus(local_bus),
		.node(node), .req(req));

	// ------------------------------------------------------------
	// Clock, stimulus helpers
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Maximal-length feedback, so the sequence never sticks at zero
	function automatic void rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
	endfunction

	// Bounded wait for hready so a stuck slave ends the run
	task automatic wait_ready();
		int i;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (hreadyout !== 1'b1 && i < 20);
		if (i >= 20) begin
			n_mismatch++;
			complete_run();
		end
	endtask

	task automatic bus(input logic wr, input logic [11:0] a, input word_t d, output word_t r);
		haddr <= {20'h0, a};
		hwrite <= wr;
		htrans <= 2'b10;
		wait_ready();
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
		r = hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input word_t d);
		word_t r;
		bus(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [11:0] a, input word_t e);
		word_t r;
		bus(1'b0, a, lfsr, r);
		`CHK(r, e)
		`CHK(hresp, 1'b0)
	endtask

	// Expected routing: ahi, alo, phi, plo held in flt[0..3]
	function automatic decision_s expect_of(logic ph, logic lb, logic [5:0] n);
		logic acc, ok;
		acc = flt[2][31] | flt[0][31];
		ok = flt[2][31];
		if (lb) begin
			acc = (n == 6'h3f) ? 1'b0 : (n[5] ? flt[0][n[4:0]] : flt[1][n[4:0]]);
			ok = n[5] ? flt[2][n[4:0]] : flt[3][n[4:0]];
		end
		return '{1'b1, acc, acc & ph & ok, acc & ~(ph & ok)};
	endfunction

	task automatic send(input logic ph, input logic lb, input logic [5:0] n);
		exp_q.push_back(expect_of(ph, lb, n));
		fire <= 1'b1;
		phys <= ph;
		local_bus <= lb;
		node <= n;
		@(posedge clk);
	endtask

	// Watcher: each decision pulse consumes the oldest expectation
	always @(negedge clk) begin
		if (decision.valid !== 1'b0 && exp_q.size() == 0) begin
			n_mismatch++;
			$display("wrong value at %0t: unexpected decision", $time);
		end else if (decision.valid !== 1'b0) begin
			got_exp = exp_q.pop_front();
			`CHK(decision, got_exp)
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{rst, hsel, hwrite, fire, phys, local_bus} = 6'b110000;
		{haddr, htrans, hsize, node, hwdata} = {32'h0, 2'b00, 3'b010, 6'h0, 32'h0};
		lfsr = 32'hb2b65fb8;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd(`PHYS_LOW_SET_OFS, `FILTER_RESET);
		rd(`PHYS_HIGH_CLR_OFS, `FILTER_RESET);
		wr(`PHYS_BOUND_OFS, lfsr);
		rd(`PHYS_BOUND_OFS, `BOUND_VALUE);
		wr(12'h1fc, lfsr);
		rd(12'h1fc, 32'h0);
		for (int t = 0; t < 4; t++) begin
			for (int k = 0; k < 4; k++) begin
				rnd();
				wr(12'h104 + 12'(k * 8), 32'hffff_ffff);
				flt[k] = (k == 2) ? {t[0], lfsr[30:0]} : lfsr;
				wr(12'h100 + 12'(k * 8), flt[k]);
				rnd();
				wr(12'h104 + 12'(k * 8), lfsr & 32'h7fff_ffff);
				flt[k] = flt[k] & ~(lfsr & 32'h7fff_ffff);
				rd(12'h100 + 12'(k * 8), flt[k]);
				rd(12'h104 + 12'(k * 8), flt[k]);
			end
			// Back-to-back sweep of every local node, then remote sources
			for (int n = 0; n < 64; n++) begin
				rnd();
				send(lfsr[0], 1'b1, 6'(n));
			end
			for (int n = 0; n < 4; n++) begin
				rnd();
				send(lfsr[0], 1'b0, lfsr[8:3]);
			end
			fire <= 1'b0;
			repeat (4) @(posedge clk);
		end
		`CHK(exp_q.size(), 0)
		complete_run();
	end
endmodule

`default_nettype wire
